/* irq_router_pkg.sv */
// Shared constants, register map and carrier types of the interrupt router
`default_nettype none
package irq_router_pkg;
  localparam int NUM_SRC = 56;
  localparam int PRIO_W = 4;
  localparam int IDX_W = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_TGT = 2;
  localparam int RAW_HI_W = NUM_SRC - 32;

  // Target codes of the per-input routing field
  localparam logic TGT_FAST = 1'h0;
  localparam logic TGT_NORM = 1'h1;

  // Word addresses on the register bus
  localparam logic [ADDR_W-1:0] REG_THRESH_FAST = 8'h00;
  localparam logic [ADDR_W-1:0] REG_THRESH_NORM = 8'h01;
  localparam logic [ADDR_W-1:0] REG_RAW_LO = 8'h02;
  localparam logic [ADDR_W-1:0] REG_RAW_HI = 8'h03;
  localparam logic [ADDR_W-1:0] REG_VEC_FAST = 8'h04;
  localparam logic [ADDR_W-1:0] REG_VEC_NORM = 8'h05;
  localparam logic [ADDR_W-1:0] REG_CFG_BASE = 8'h40;

  // Field positions of a per-input configuration word
  localparam int CFG_PRIO_LSB = 0;
  localparam int CFG_TGT_BIT = 4;
  localparam int CFG_INV_BIT = 5;
  localparam int CFG_SW_BIT = 6;

  // Field positions of a vector word
  localparam int VEC_IDX_LSB = 0;
  localparam int VEC_LEVEL_LSB = 8;
  localparam int VEC_VALID_BIT = 31;

  localparam logic [PRIO_W-1:0] THRESH_RST = 4'h0;
  localparam logic [PRIO_W-1:0] PRIO_MASKED = 4'h0;

  typedef struct packed {
    logic swReq;
    logic invert;
    logic target;
    logic [PRIO_W-1:0] prio;
  } srcCfg_t;

  localparam srcCfg_t CFG_RST = '0;

  typedef struct packed {
    logic valid;
    logic [PRIO_W-1:0] level;
    logic [IDX_W-1:0] idx;
  } winner_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } busState_t;
endpackage
`default_nettype wire

/* irq_priority_arbiter.sv */
// Picks the highest-priority qualifying request for one processor target
`default_nettype none
module irq_priority_arbiter
  import irq_router_pkg::*;
#(
  parameter logic TARGET = TGT_FAST
) (
  input wire logic [NUM_SRC-1:0] active,
  input wire srcCfg_t cfg [NUM_SRC],
  input wire logic [PRIO_W-1:0] thresh,
  output var winner_t winner
);
  // Strict compare keeps the lowest index on a tie
  always_comb begin
    winner = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (active[i] && cfg[i].target == TARGET && cfg[i].prio > thresh && cfg[i].prio > winner.level) begin
        winner.valid = 1'b1;
        winner.level = cfg[i].prio;
        winner.idx = IDX_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* vectored_request_controller.sv */
// Vectored interrupt router: request qualification, routing, vectors and Avalon-MM registers
//
// Functional notes
// R1: 56 level inputs, polarity chosen per input
// R2: Software request bit acts like hardware request
// R3: Active request state readable before masking
// R4: Each input has a 4-bit priority
// R5: Each input selects fast or normal target
// R6: Two outputs: fast and normal interrupt lines
// R7: Target value 0 means fast line
// R8: Target value 1 means normal line
// R9: Per-target threshold masks requests by priority
// R10: Priority 0 never raises any interrupt
// R11: Priority 1 is the lowest active level
// R12: Priority 15 is the highest level
// R13: Vector register names the winning request
// R14: Nesting via raisable per-target thresholds
// R15: Everything runs on one branch clock
// R16: Forward only priorities above threshold; highest wins
// R17: Software raises threshold during service, restores after
`default_nettype none
module vectored_request_controller
  import irq_router_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [NUM_SRC-1:0] irqIn,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic fastInterruptLine,
  output logic normInterruptLine
);
  logic rstMeta_b;
  logic sysRst_b;
  srcCfg_t cfg_r [NUM_SRC];
  logic [PRIO_W-1:0] threshFast_r;
  logic [PRIO_W-1:0] threshNorm_r;
  logic [NUM_SRC-1:0] active;
  winner_t winFast;
  winner_t winNorm;
  winner_t vecFast_r;
  winner_t vecNorm_r;
  logic fastLine_r;
  logic normLine_r;
  busState_t busState_r;
  busState_t busState_nxt;
  logic waitReq_r;
  logic [DATA_W-1:0] readData_r;
  logic [DATA_W-1:0] readMux;
  logic busReq;
  logic writeCommit;

  function automatic logic cfgHit(input logic [ADDR_W-1:0] addr);
    cfgHit = (addr >= REG_CFG_BASE) && (addr < REG_CFG_BASE + ADDR_W'(NUM_SRC));
  endfunction

  function automatic logic [IDX_W-1:0] cfgIndex(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] offs;
    offs = addr - REG_CFG_BASE;
    cfgIndex = offs[IDX_W-1:0];
  endfunction

  function automatic logic [DATA_W-1:0] vecWord(input winner_t w);
    logic [DATA_W-1:0] v;
    v = '0;
    v[VEC_VALID_BIT] = w.valid;
    v[VEC_LEVEL_LSB +: PRIO_W] = w.level;
    v[VEC_IDX_LSB +: IDX_W] = w.idx;
    vecWord = v;
  endfunction

  // Reset is released through two flops so that all state leaves reset together
  always_ff @(posedge ref_clk or negedge rst_b) begin // [R15]
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      sysRst_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      sysRst_b <= rstMeta_b;
    end
  end

  // Request qualification: polarity applied, then software request merged in
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_active
      assign active[i] = (irqIn[i] ^ cfg_r[i].invert) | cfg_r[i].swReq; // [R1] [R2]
      a_sw_request_raises: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        cfg_r[i].swReq && cfg_r[i].target == TGT_NORM && cfg_r[i].prio > threshNorm_r |=> normLine_r) // [R2]
        else $error("software request did not reach the normal line");
      a_sw_request_fast: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        cfg_r[i].swReq && cfg_r[i].target == TGT_FAST && cfg_r[i].prio > threshFast_r |=> fastLine_r) // [R2]
        else $error("software request did not reach the fast line");
    end
  endgenerate

  // Avalon-MM slave: one wait cycle, write committed on the edge that sees waitrequest low
  assign busReq = read | write;
  assign writeCommit = write && busState_r == BUS_ACK;

  always_comb begin
    busState_nxt = busState_r;
    unique case (busState_r)
      BUS_IDLE: begin
        if (busReq) begin
          busState_nxt = BUS_ACK;
        end
      end
      BUS_ACK: begin
        busState_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge sysRst_b) begin
    if (!sysRst_b) begin
      busState_r <= BUS_IDLE;
      waitReq_r <= 1'b1;
    end else begin
      busState_r <= busState_nxt;
      waitReq_r <= busState_nxt != BUS_ACK;
    end
  end

  a_bus_wait_one: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    busReq && waitReq_r && busState_r == BUS_IDLE |=> !waitReq_r ##1 waitReq_r)
    else $error("bus answer not given after one wait cycle");

  a_bus_idle_wait: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    busState_r == BUS_IDLE |-> waitReq_r)
    else $error("waitrequest low while the slave is idle");

  a_commit_in_ack: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    writeCommit |-> !waitReq_r)
    else $error("write committed without waitrequest low");

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    readMux = '0;
    if (cfgHit(address)) begin
      readMux[CFG_PRIO_LSB +: PRIO_W] = cfg_r[cfgIndex(address)].prio;
      readMux[CFG_TGT_BIT] = cfg_r[cfgIndex(address)].target;
      readMux[CFG_INV_BIT] = cfg_r[cfgIndex(address)].invert;
      readMux[CFG_SW_BIT] = cfg_r[cfgIndex(address)].swReq;
    end else begin
      unique case (address)
        REG_THRESH_FAST: readMux[PRIO_W-1:0] = threshFast_r;
        REG_THRESH_NORM: readMux[PRIO_W-1:0] = threshNorm_r;
        REG_RAW_LO: readMux = active[DATA_W-1:0]; // [R3]
        REG_RAW_HI: readMux[RAW_HI_W-1:0] = active[NUM_SRC-1:DATA_W]; // [R3]
        REG_VEC_FAST: readMux = vecWord(vecFast_r); // [R13]
        REG_VEC_NORM: readMux = vecWord(vecNorm_r); // [R13]
        default: readMux = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge sysRst_b) begin
    if (!sysRst_b) begin
      readData_r <= '0;
    end else if (read && busState_r == BUS_IDLE) begin
      readData_r <= readMux;
    end
  end

  // Read data is a register so the word stays put until the next read
  a_read_data_holds: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    !(read && busState_r == BUS_IDLE) |=> $stable(readData_r))
    else $error("read data changed without a read");

  a_raw_read_back: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    read && busState_r == BUS_IDLE && address == REG_RAW_LO
    |=> readData_r == $past(active[DATA_W-1:0])) // [R3]
    else $error("raw request state not returned by read");

  a_thresh_read_back: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    read && busState_r == BUS_IDLE && address == REG_THRESH_FAST
    |=> readData_r[PRIO_W-1:0] == $past(threshFast_r)) // [R9]
    else $error("fast threshold not returned by read");

  a_vec_read_back: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    read && busState_r == BUS_IDLE && address == REG_VEC_FAST
    |=> readData_r[VEC_VALID_BIT] == $past(vecFast_r.valid)
    && readData_r[VEC_IDX_LSB +: IDX_W] == $past(vecFast_r.idx)) // [R13]
    else $error("fast vector not returned by read");

  // Per-input configuration; software request stays set until software clears it
  always_ff @(posedge ref_clk or negedge sysRst_b) begin
    if (!sysRst_b) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        cfg_r[i] <= CFG_RST;
      end
    end else if (writeCommit && cfgHit(address)) begin
      cfg_r[cfgIndex(address)].prio <= writedata[CFG_PRIO_LSB +: PRIO_W]; // [R4]
      cfg_r[cfgIndex(address)].target <= writedata[CFG_TGT_BIT]; // [R5]
      cfg_r[cfgIndex(address)].invert <= writedata[CFG_INV_BIT]; // [R1]
      cfg_r[cfgIndex(address)].swReq <= writedata[CFG_SW_BIT]; // [R2]
    end
  end

  // Thresholds are free to rewrite at any time so that nested handlers can raise them
  always_ff @(posedge ref_clk or negedge sysRst_b) begin
    if (!sysRst_b) begin
      threshFast_r <= THRESH_RST;
      threshNorm_r <= THRESH_RST;
    end else if (writeCommit) begin
      if (address == REG_THRESH_FAST) begin
        threshFast_r <= writedata[PRIO_W-1:0]; // [R9] [R14]
      end
      if (address == REG_THRESH_NORM) begin
        threshNorm_r <= writedata[PRIO_W-1:0]; // [R9] [R14]
      end
    end
  end

  a_thresh_write_lands: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    writeCommit && address == REG_THRESH_FAST |=> threshFast_r == $past(writedata[PRIO_W-1:0])) // [R9]
    else $error("fast threshold write not stored");

  a_norm_thresh_lands: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    writeCommit && address == REG_THRESH_NORM |=> threshNorm_r == $past(writedata[PRIO_W-1:0])) // [R9]
    else $error("normal threshold write not stored");

  // One arbiter per target, each against its own threshold
  irq_priority_arbiter #(
    .TARGET(TGT_FAST)
  ) u_arbFast (
    .active(active),
    .cfg(cfg_r),
    .thresh(threshFast_r),
    .winner(winFast)
  ); // [R7] [R9] [R16]

  irq_priority_arbiter #(
    .TARGET(TGT_NORM)
  ) u_arbNorm (
    .active(active),
    .cfg(cfg_r),
    .thresh(threshNorm_r),
    .winner(winNorm)
  ); // [R8] [R9] [R16]

  a_above_thresh: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    winFast.valid |-> winFast.level > threshFast_r && cfg_r[winFast.idx].target == TGT_FAST) // [R16]
    else $error("fast winner not above threshold or misrouted");

  a_masked_level: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    winNorm.valid |-> winNorm.level != PRIO_MASKED && cfg_r[winNorm.idx].target == TGT_NORM) // [R10]
    else $error("masked or misrouted request reached normal line");

  a_norm_above_thresh: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    winNorm.valid |-> winNorm.level > threshNorm_r && cfg_r[winNorm.idx].target == TGT_NORM) // [R9] [R16]
    else $error("normal winner not above threshold or misrouted");

  a_fast_masked_level: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    winFast.valid |-> winFast.level != PRIO_MASKED) // [R10]
    else $error("masked request reached fast line");

  a_winner_active: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    (!winFast.valid || active[winFast.idx]) && (!winNorm.valid || active[winNorm.idx])) // [R1] [R2]
    else $error("winner is not an active request");

  // Each configuration field lands on the addressed input, and an input at priority 0 never wins either arbiter
  generate
    for (genvar k = 0; k < NUM_SRC; k++) begin : g_cfg_check
      a_prio_write_lands: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        writeCommit && address == REG_CFG_BASE + ADDR_W'(k)
        |=> cfg_r[k].prio == $past(writedata[CFG_PRIO_LSB +: PRIO_W])) // [R4]
        else $error("priority write not stored");
      a_target_write_lands: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        writeCommit && address == REG_CFG_BASE + ADDR_W'(k)
        |=> cfg_r[k].target == $past(writedata[CFG_TGT_BIT])) // [R5]
        else $error("target select write not stored");
      a_invert_write_lands: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        writeCommit && address == REG_CFG_BASE + ADDR_W'(k)
        |=> cfg_r[k].invert == $past(writedata[CFG_INV_BIT])) // [R1]
        else $error("polarity write not stored");
      a_sw_write_lands: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        writeCommit && address == REG_CFG_BASE + ADDR_W'(k)
        |=> cfg_r[k].swReq == $past(writedata[CFG_SW_BIT])) // [R2]
        else $error("software request write not stored");
      a_masked_silent: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        cfg_r[k].prio == PRIO_MASKED
        |-> !(winFast.valid && winFast.idx == IDX_W'(k))
        && !(winNorm.valid && winNorm.idx == IDX_W'(k))) // [R10]
        else $error("masked input won arbitration");
    end
  endgenerate

  generate
    for (genvar j = 0; j < NUM_SRC; j++) begin : g_order
      a_highest_wins: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        active[j] && cfg_r[j].target == TGT_FAST && cfg_r[j].prio > threshFast_r
        |-> winFast.valid && winFast.level >= cfg_r[j].prio) // [R11] [R12]
        else $error("lower priority request chosen over a higher one");
      a_norm_highest_wins: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        active[j] && cfg_r[j].target == TGT_NORM && cfg_r[j].prio > threshNorm_r
        |-> winNorm.valid && winNorm.level >= cfg_r[j].prio) // [R11] [R12]
        else $error("lower priority request chosen on the normal line");
      // Equal levels go to the lowest input so the vector never hops between equals
      a_tie_low_index: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
        active[j] && cfg_r[j].target == TGT_FAST && winFast.valid && cfg_r[j].prio == winFast.level
        |-> winFast.idx <= IDX_W'(j)) // [R16]
        else $error("tie not resolved to the lowest input");
    end
  endgenerate

  // Outputs and vectors registered so the core sees glitch-free levels
  always_ff @(posedge ref_clk or negedge sysRst_b) begin
    if (!sysRst_b) begin
      fastLine_r <= 1'b0;
      normLine_r <= 1'b0;
      vecFast_r <= '0;
      vecNorm_r <= '0;
    end else begin
      fastLine_r <= winFast.valid; // [R6] [R7]
      normLine_r <= winNorm.valid; // [R6] [R8]
      vecFast_r <= winFast; // [R13]
      vecNorm_r <= winNorm; // [R13]
    end
  end

  a_fast_line_follows: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    ##1 fastLine_r == $past(winFast.valid)) // [R6]
    else $error("fast line does not track its arbiter");

  a_norm_line_follows: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    ##1 normLine_r == $past(winNorm.valid)) // [R6]
    else $error("normal line does not track its arbiter");

  a_vector_matches: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    winNorm.valid ##1 normLine_r |-> vecNorm_r.valid && vecNorm_r.idx == $past(winNorm.idx)) // [R13]
    else $error("normal vector does not name the winner");

  a_fast_vector_matches: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    winFast.valid ##1 fastLine_r |-> vecFast_r.valid && vecFast_r.idx == $past(winFast.idx)) // [R13]
    else $error("fast vector does not name the winner");

  a_line_drops_on_thresh: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    normLine_r |-> vecNorm_r.level > $past(threshNorm_r)) // [R14]
    else $error("normal line high at or below its threshold");

  a_fast_line_drops: assert property (@(posedge ref_clk) disable iff (!sysRst_b)
    fastLine_r |-> vecFast_r.level > $past(threshFast_r)) // [R14]
    else $error("fast line high at or below its threshold");

  assign readdata = readData_r;
  assign waitrequest = waitReq_r;
  assign fastInterruptLine = fastLine_r;
  assign normInterruptLine = normLine_r;
endmodule
`default_nettype wire

/* irq_source_model.sv */
// Peripheral request sources and processor-side sampling of the two interrupt lines
`default_nettype none
module irq_source_model
  import irq_router_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [NUM_SRC-1:0] reqLevels,
  input wire logic fastInterruptLine,
  input wire logic normInterruptLine,
  output logic [NUM_SRC-1:0] irqIn,
  output logic [1:0] coreLines
);
  timeunit 1ns;
  timeprecision 100ps;
  // Sources launch levels on the clock edge, like any synchronous peripheral
  always @(posedge ref_clk) begin
    irqIn <= reqLevels;
  end
  // Core sees its inputs through one sampling stage, so checks lag one cycle
  always @(posedge ref_clk) begin
    coreLines <= {fastInterruptLine, normInterruptLine};
  end
endmodule
`default_nettype wire

/* vectored_request_controller_tb.sv */
// Self-checking bench for the vectored interrupt router
`default_nettype none
`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %0t got %h expected %h", $time, got, exp); end end
module vectored_request_controller_tb
  import irq_router_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [NUM_SRC-1:0] reqLevels = '0;
  logic [NUM_SRC-1:0] irqIn;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [DATA_W-1:0] readdata;
  logic [DATA_W-1:0] rd;
  logic waitrequest;
  logic fastInterruptLine;
  logic normInterruptLine;
  logic [1:0] coreLines;
  int mismatches = 0;
  int checksDone = 0;

  always #5 ref_clk = ~ref_clk;

  vectored_request_controller dut (.ref_clk(ref_clk), .rst_b(rst_b), .irqIn(irqIn), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .fastInterruptLine(fastInterruptLine), .normInterruptLine(normInterruptLine));
  irq_source_model partner (.ref_clk(ref_clk), .reqLevels(reqLevels), .fastInterruptLine(fastInterruptLine),
    .normInterruptLine(normInterruptLine), .irqIn(irqIn), .coreLines(coreLines));

  // Request is held until waitrequest is seen low at a rising edge
  task automatic busDo(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic cfg(input int i, input logic [3:0] p, input logic t, input logic inv, input logic sw);
    busDo(1'b1, 8'(REG_CFG_BASE + i), {25'h0, sw, inv, t, p});
  endtask

  task automatic chkReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    busDo(1'b0, a, '0);
    `CHK(rd, e)
  endtask

  // Lines reach the core model four negedges after the sources change
  task automatic drive(input logic [NUM_SRC-1:0] lv, input logic [1:0] e);
    @(posedge ref_clk);
    reqLevels <= lv;
    repeat (4) @(negedge ref_clk);
    `CHK(coreLines, e)
  endtask

  function automatic logic [DATA_W-1:0] vec(input logic [3:0] l, input logic [5:0] i);
    return {1'b1, 19'h0, l, 2'h0, i};
  endfunction

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    endOfTest();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chkReg(REG_THRESH_FAST, 32'h0000_0000);
    chkReg(REG_CFG_BASE, 32'h0000_0000);
    drive(56'h1 << 3, 2'b00);
    cfg(3, 4'h5, TGT_FAST, 1'b0, 1'b0);
    drive(56'h1 << 3, 2'b10);
    chkReg(REG_VEC_FAST, vec(4'h5, 6'h03));
    cfg(3, 4'h5, TGT_NORM, 1'b0, 1'b0);
    drive(56'h1 << 3, 2'b01);
    chkReg(REG_VEC_NORM, vec(4'h5, 6'h03));
    cfg(3, 4'h5, TGT_FAST, 1'b0, 1'b0);
    busDo(1'b1, REG_THRESH_FAST, 32'h0000_0005);
    drive(56'h1 << 3, 2'b00);
    busDo(1'b1, REG_THRESH_FAST, 32'h0000_0004);
    drive(56'h1 << 3, 2'b10);
    busDo(1'b1, REG_THRESH_FAST, 32'h0000_0000);
    cfg(10, 4'h1, TGT_FAST, 1'b0, 1'b0);
    cfg(20, 4'h1, TGT_FAST, 1'b0, 1'b0);
    cfg(50, 4'hF, TGT_FAST, 1'b0, 1'b0);
    chkReg(8'(REG_CFG_BASE + 50), 32'h0000_000F);
    drive((56'h1 << 3) | (56'h1 << 10) | (56'h1 << 20) | (56'h1 << 50), 2'b10);
    chkReg(REG_VEC_FAST, vec(4'hF, 6'h32));
    drive((56'h1 << 10) | (56'h1 << 20), 2'b10);
    chkReg(REG_VEC_FAST, vec(4'h1, 6'h0A));
    cfg(10, 4'h0, TGT_FAST, 1'b0, 1'b0);
    drive(56'h1 << 10, 2'b00);
    // Inverted input reads active while its pin sits low, masked by priority 0
    cfg(7, 4'h0, TGT_FAST, 1'b1, 1'b0);
    drive('0, 2'b00);
    chkReg(REG_RAW_LO, 32'h0000_0080);
    cfg(40, 4'h2, TGT_NORM, 1'b0, 1'b1);
    drive('0, 2'b01);
    chkReg(REG_RAW_HI, 32'h0000_0100);
    // Servicing the priority 2 request: threshold raised to its level
    busDo(1'b1, REG_THRESH_NORM, 32'h0000_0002);
    drive('0, 2'b00);
    cfg(41, 4'h9, TGT_NORM, 1'b0, 1'b0);
    drive(56'h1 << 41, 2'b01);
    chkReg(REG_VEC_NORM, vec(4'h9, 6'h29));
    busDo(1'b1, REG_THRESH_NORM, 32'h0000_0000);
    cfg(40, 4'h2, TGT_NORM, 1'b0, 1'b0);
    chkReg(REG_RAW_HI, 32'h0000_0200);
    // Unmapped word reads back as zero
    chkReg(8'h20, 32'h0000_0000);
    endOfTest();
  end
endmodule
`default_nettype wire
